/* File: common/dabm_params.svh */
// constants for the dual converter power and bus steering block
`ifndef DABM_PARAMS_SVH
`define DABM_PARAMS_SVH
`define DABM_DATA_W 14
`define DABM_FIFO_DEPTH 4
`define DABM_NAP_RECOVERY_CYCLES 100
`define DABM_CLK_PERIOD_NS 40
`define DABM_SLEEP_SETTLE_US 1000
`define DABM_SLEEP_SETTLE_CYCLES ((`DABM_SLEEP_SETTLE_US * 1000) / `DABM_CLK_PERIOD_NS)
`define DABM_CNT_W 16
`define DABM_ADDR_CTRL 12'h000
`define DABM_ADDR_STATUS 12'h004
`define DABM_CTRL_RESET 32'h0000_0000
`define DABM_CTRL_SWAP_BIT 0
`define DABM_CTRL_PD_A_BIT 1
`define DABM_CTRL_OD_A_BIT 2
`define DABM_CTRL_PD_B_BIT 3
`define DABM_CTRL_OD_B_BIT 4
`endif

/* File: common/dabm_pkg.sv */
// types for the dual converter power and bus steering block
package dabm_pkg;
  typedef enum logic [1:0] {
    DABM_NORMAL = 2'b00,
    DABM_NAP = 2'b01,
    DABM_SLEEP = 2'b10
  } dabm_power_t;
  typedef struct packed {
    logic [13:0] data;
    logic range_flag;
  } dabm_sample_t;
endpackage

/* File: rtl/dabm_fifo.sv */
// small valid/ready fifo carrying one channel's samples
`timescale 1ns/1ps
`default_nettype none
module dabm_fifo #(
  parameter int WIDTH = 15,
  parameter int DEPTH = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic flush,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic push;
  logic pop;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign in_ready = (count != DEPTH[AW:0]);
  assign out_valid = (count != '0);
  assign out_data = mem[rd_ptr];
  always_ff @(posedge pclk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else if (flush) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

/* File: rtl/dabm_top.sv */
// power state control, recovery tracking and bus steering of the dual converter
// Overview of operation
// RULE_01: a channel whose power-down request is low runs normally regardless of its output disable.
// RULE_02: power-down high with output disable high puts the channel into sleep, all circuitry off.
// RULE_03: after sleep the channel's data is held invalid for a settling period of milliseconds order.
// RULE_04: power-down high with output disable low puts the channel into nap, reference kept on.
// RULE_05: after nap the channel needs 100 sample clocks before its data is valid.
// RULE_06: in nap or sleep every output driven by that channel is released to high impedance.
// RULE_07: each channel has its own power-down and output-disable controls, fully independent.
// RULE_08: one channel may convert while the other naps or sleeps.
// RULE_09: with swap select high, channel a goes to bus a and channel b to bus b.
// RULE_10: with swap select low, channel a goes to bus b and channel b to bus a.
// RULE_11: for interleaving the outside ties swap select and both sample clocks together.
// RULE_12: when interleaved the outside may use either bus and disable the other.
// RULE_13: output disable high floats all of that channel's outputs including its range flag.
// RULE_14: each channel's data-valid stays low from any nap or sleep exit until recovery ends.
`include "dabm_params.svh"
`timescale 1ns/1ps
`default_nettype none
module dabm_top
  import dabm_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sample_valid_a,
  output logic sample_ready_a,
  input wire dabm_sample_t sample_in_a,
  input wire logic sample_valid_b,
  output logic sample_ready_b,
  input wire dabm_sample_t sample_in_b,
  output logic [13:0] bus_a_data,
  output logic range_flag_bus_a,
  output logic bus_a_oe_n,
  output logic bus_a_strobe,
  output logic [13:0] bus_b_data,
  output logic range_flag_bus_b,
  output logic bus_b_oe_n,
  output logic bus_b_strobe,
  output logic data_valid_a,
  output logic data_valid_b
);
  logic [31:0] ctrl;
  logic bus_swap_select;
  logic [1:0] power_down_request;
  logic [1:0] output_disable;
  dabm_power_t pstate [2];
  dabm_power_t next_pstate [2];
  logic [`DABM_CNT_W-1:0] recover_cnt [2];
  logic [1:0] recovering;
  logic [1:0] ch_valid;
  logic [1:0] ch_drive;
  logic [1:0] fifo_out_valid;
  logic [1:0] fifo_out_ready;
  dabm_sample_t fifo_out [2];
  dabm_sample_t held [2];
  logic [1:0] held_new;
  logic apb_access;
  logic apb_wr;

  assign apb_access = psel && penable;
  assign apb_wr = apb_access && pwrite;
  assign bus_swap_select = ctrl[`DABM_CTRL_SWAP_BIT];
  // separate control bits per channel
  assign power_down_request[0] = ctrl[`DABM_CTRL_PD_A_BIT]; // RULE_07
  assign output_disable[0] = ctrl[`DABM_CTRL_OD_A_BIT];
  assign power_down_request[1] = ctrl[`DABM_CTRL_PD_B_BIT]; // RULE_07
  assign output_disable[1] = ctrl[`DABM_CTRL_OD_B_BIT];

  // zero wait states keep software timing simple
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= `DABM_CTRL_RESET;
    end else if (apb_wr && paddr == `DABM_ADDR_CTRL) begin
      ctrl <= {27'h0000000, pwdata[4:0]};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && paddr != `DABM_ADDR_CTRL && paddr != `DABM_ADDR_STATUS;
      if (psel && !penable && !pwrite) begin
        unique case (paddr)
          `DABM_ADDR_CTRL: prdata <= ctrl;
          `DABM_ADDR_STATUS: prdata <= {24'h000000, pstate[1], pstate[0], ch_valid, recovering};
          default: prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  generate
    for (genvar c = 0; c < 2; c++) begin : g_ch
      always_comb begin
        if (!power_down_request[c]) begin
          next_pstate[c] = DABM_NORMAL; // RULE_01
        end else if (output_disable[c]) begin
          next_pstate[c] = DABM_SLEEP; // RULE_02
        end else begin
          next_pstate[c] = DABM_NAP; // RULE_04
        end
      end

      // each channel's machine is independent of the other
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          pstate[c] <= DABM_NORMAL;
        end else begin
          pstate[c] <= next_pstate[c]; // RULE_08
        end
      end

      // recovery counter; reset counts as a sleep exit, reference cold
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          recover_cnt[c] <= `DABM_CNT_W'(`DABM_SLEEP_SETTLE_CYCLES);
        end else if (pstate[c] == DABM_SLEEP) begin
          recover_cnt[c] <= `DABM_CNT_W'(`DABM_SLEEP_SETTLE_CYCLES); // RULE_03
        end else if (pstate[c] == DABM_NAP) begin
          recover_cnt[c] <= `DABM_CNT_W'(`DABM_NAP_RECOVERY_CYCLES); // RULE_05
        end else if (recover_cnt[c] != '0) begin
          recover_cnt[c] <= recover_cnt[c] - 1'b1;
        end
      end
      assign recovering[c] = (recover_cnt[c] != '0);

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          ch_valid[c] <= 1'b0;
        end else begin
          ch_valid[c] <= pstate[c] == DABM_NORMAL && next_pstate[c] == DABM_NORMAL &&
                         recover_cnt[c] <= `DABM_CNT_W'(1); // RULE_14
        end
      end

      // outputs float in nap, sleep, or when disabled
      assign ch_drive[c] = !output_disable[c] && next_pstate[c] == DABM_NORMAL; // RULE_06 RULE_13

      // drain while valid or out of normal, so samples held in recovery stall the source
      assign fifo_out_ready[c] = ch_valid[c] || pstate[c] != DABM_NORMAL;

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          held[c] <= '0;
          held_new[c] <= 1'b0;
        end else begin
          held_new[c] <= fifo_out_valid[c] && ch_valid[c];
          if (fifo_out_valid[c] && ch_valid[c]) begin
            held[c] <= fifo_out[c];
          end
        end
      end
    end
  endgenerate

  dabm_fifo #(
    .WIDTH(`DABM_DATA_W + 1),
    .DEPTH(`DABM_FIFO_DEPTH)
  ) u_fifo_a (
    .pclk(pclk),
    .presetn(presetn),
    .flush(pstate[0] != DABM_NORMAL),
    .in_valid(sample_valid_a),
    .in_ready(sample_ready_a),
    .in_data(sample_in_a),
    .out_valid(fifo_out_valid[0]),
    .out_ready(fifo_out_ready[0]),
    .out_data(fifo_out[0])
  );

  dabm_fifo #(
    .WIDTH(`DABM_DATA_W + 1),
    .DEPTH(`DABM_FIFO_DEPTH)
  ) u_fifo_b (
    .pclk(pclk),
    .presetn(presetn),
    .flush(pstate[1] != DABM_NORMAL),
    .in_valid(sample_valid_b),
    .in_ready(sample_ready_b),
    .in_data(sample_in_b),
    .out_valid(fifo_out_valid[1]),
    .out_ready(fifo_out_ready[1]),
    .out_data(fifo_out[1])
  );

  // steering; output enable of a bus follows the channel routed to it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_a_data <= '0;
      range_flag_bus_a <= 1'b0;
      bus_a_oe_n <= 1'b1;
      bus_a_strobe <= 1'b0;
      bus_b_data <= '0;
      range_flag_bus_b <= 1'b0;
      bus_b_oe_n <= 1'b1;
      bus_b_strobe <= 1'b0;
    end else if (bus_swap_select) begin
      bus_a_data <= held[0].data; // RULE_09
      range_flag_bus_a <= held[0].range_flag;
      bus_a_oe_n <= !ch_drive[0];
      bus_a_strobe <= held_new[0];
      bus_b_data <= held[1].data;
      range_flag_bus_b <= held[1].range_flag;
      bus_b_oe_n <= !ch_drive[1];
      bus_b_strobe <= held_new[1];
    end else begin
      bus_a_data <= held[1].data; // RULE_10
      range_flag_bus_a <= held[1].range_flag;
      bus_a_oe_n <= !ch_drive[1];
      bus_a_strobe <= held_new[1];
      bus_b_data <= held[0].data;
      range_flag_bus_b <= held[0].range_flag;
      bus_b_oe_n <= !ch_drive[0];
      bus_b_strobe <= held_new[0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_valid_a <= 1'b0;
      data_valid_b <= 1'b0;
    end else begin
      data_valid_a <= ch_valid[0];
      data_valid_b <= ch_valid[1];
    end
  end
endmodule
`default_nettype wire

/* File: testbench/dabm_capture.sv */
// far-side capture logic latching each word shown on one output bus
`timescale 1ns/1ps
`default_nettype none
module dabm_capture (
  input wire logic pclk,
  input wire logic strobe,
  input wire logic oe_n,
  input wire logic [13:0] data,
  input wire logic flag,
  output logic [14:0] last
);
  initial last = 15'h0;
  // a released bus carries nothing usable, so only driven words are taken
  always @(posedge pclk) if (strobe && !oe_n) last <= {data, flag};
endmodule
`default_nettype wire

/* File: testbench/dabm_top_monitor.sv */
// concurrent checks on the ports of the steering block
`timescale 1ns/1ps
`default_nettype none
module dabm_top_monitor (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic bus_a_oe_n,
  input wire logic bus_b_oe_n,
  input wire logic data_valid_a
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire wr = psel && penable && pready && pwrite && paddr == 12'h000;
  wire [4:0] ctl = pwdata[4:0];
  a_apb_answer: assert property (psel && !penable |=> pready ##1 !pready) else $error("pready not one pulse");
  a_bad_addr: assert property (psel && !penable && paddr > 12'h004 |=> pslverr) else $error("no slave error");
  a_oe_a_off: assert property (wr && ctl[0] && (ctl[1] || ctl[2]) |-> ##5 bus_a_oe_n)
    else $error("bus a still driven");
  a_oe_b_off: assert property (wr && ctl[0] && (ctl[3] || ctl[4]) |-> ##5 bus_b_oe_n)
    else $error("bus b still driven");
  a_swap_low: assert property (wr && ctl == 5'h04 |-> ##5 bus_b_oe_n && !bus_a_oe_n)
    else $error("buses not exchanged");
  a_nap_drop: assert property (wr && ctl[1] |-> ##4 !data_valid_a)
    else $error("valid kept in power down");
  a_normal_on: assert property (wr && ctl[4:1] == 4'h0 |-> ##5 !bus_a_oe_n && !bus_b_oe_n)
    else $error("normal channel not driving");
  a_rise_late: assert property ($rose(data_valid_a) |-> !$past(data_valid_a, 40))
    else $error("valid back too soon");
endmodule
bind dabm_top dabm_top_monitor mon_u (.*);
`default_nettype wire

/* File: testbench/test_dual_adc_power_and_bus_mux.sv */
// self-checking bench for the dual converter power and bus steering block
`timescale 1ns/1ps
`default_nettype none
module test_dual_adc_power_and_bus_mux;
  import dabm_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic sample_valid_a = 1'b0, sample_valid_b = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  dabm_sample_t sample_in_a = 15'h0, sample_in_b = 15'h0;
  logic pready, pslverr, sample_ready_a, sample_ready_b, range_flag_bus_a, range_flag_bus_b, serr;
  logic bus_a_oe_n, bus_b_oe_n, bus_a_strobe, bus_b_strobe, data_valid_a, data_valid_b;
  logic [13:0] bus_a_data, bus_b_data;
  logic [14:0] last_a, last_b;
  int err_total = 0, n_tests = 0, n, k;
  always #20 pclk = ~pclk;
  dabm_top dut_u (.*);
  dabm_capture cap_a (.pclk, .strobe(bus_a_strobe), .oe_n(bus_a_oe_n), .data(bus_a_data),
    .flag(range_flag_bus_a), .last(last_a));
  dabm_capture cap_b (.pclk, .strobe(bus_b_strobe), .oe_n(bus_b_oe_n), .data(bus_b_data),
    .flag(range_flag_bus_b), .last(last_b));
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int t;
    t = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1 && ++t < 20);
    chk("pready", 1'b1, pready);
    rd = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    repeat (6) @(posedge pclk);
  endtask
  // n carries on from the caller so recovery times include the write tail
  task automatic wait_valid(input bit ch);
    while ((ch ? data_valid_b : data_valid_a) !== 1'b1 && n < 30000) begin
      @(posedge pclk);
      n++;
    end
  endtask
  // both streams move on the one bench clock, as when the sample clocks are tied
  task automatic push(input logic [14:0] a, input logic [14:0] b);
    sample_in_a <= a;
    sample_in_b <= b;
    sample_valid_a <= 1'b1;
    sample_valid_b <= 1'b1;
    @(posedge pclk);
    sample_valid_a <= 1'b0;
    sample_valid_b <= 1'b0;
    repeat (6) @(posedge pclk);
  endtask
  task automatic t_regs;
    apb(1'b0, 12'h000, 32'h0);
    chk("ctrl reset", 32'h0, rd);
    apb(1'b1, 12'h008, 32'h1f);
    chk("unmapped error", 1'b1, serr);
    apb(1'b1, 12'h004, 32'hff);
    n = 0;
    wait_valid(1'b0);
    wait_valid(1'b1);
    apb(1'b0, 12'h004, 32'h0);
    chk("status", 8'h0c, rd[7:0]);
  endtask
  task automatic t_swap;
    apb(1'b1, 12'h000, 32'h1);
    push(15'h1235, 15'h2a4b);
    chk("bus a", 15'h1235, last_a);
    chk("bus b", 15'h2a4b, last_b);
    apb(1'b1, 12'h000, 32'h0);
    push(15'h0c01, 15'h3ffe);
    chk("bus b", 15'h0c01, last_b);
    chk("bus a", 15'h3ffe, last_a);
  endtask
  task automatic t_nap;
    apb(1'b1, 12'h000, 32'h3);
    apb(1'b0, 12'h004, 32'h0);
    chk("nap status", 6'h06, rd[7:2]);
    chk("nap oe", 2'b01, {bus_b_oe_n, bus_a_oe_n});
    apb(1'b1, 12'h000, 32'h1);
    sample_valid_a <= 1'b1;
    k = 0;
    n = 6;
    do begin
      @(posedge pclk);
      n++;
      if (sample_ready_a === 1'b1) k++;
      sample_in_a <= sample_in_a + 15'h2;
    end while (sample_ready_a === 1'b1 && k < 8);
    sample_valid_a <= 1'b0;
    chk("held words", 4, k);
    wait_valid(1'b0);
    chk("nap recovery", 1'b1, n >= 100 && n <= 106);
    repeat (12) @(posedge pclk);
    chk("drained", 15'h0c07, last_a);
  endtask
  task automatic t_sleep;
    apb(1'b1, 12'h000, 32'h19);
    apb(1'b0, 12'h004, 32'h0);
    chk("sleep status", 6'h21, rd[7:2]);
    chk("sleep oe", 2'b10, {bus_b_oe_n, bus_a_oe_n});
    apb(1'b1, 12'h000, 32'h4);
    n = 6;
    wait_valid(1'b1);
    chk("sleep recovery", 1'b1, n >= 25000 && n <= 25006);
    apb(1'b0, 12'h004, 32'h0);
    chk("disabled status", 6'h03, rd[7:2]);
    chk("disabled oe", 2'b10, {bus_b_oe_n, bus_a_oe_n});
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_regs;
    t_swap;
    t_nap;
    t_sleep;
    print_verdict;
  end
  initial begin
    repeat (60000) @(posedge pclk);
    err_total++;
    print_verdict;
  end
endmodule
`default_nettype wire
